/* File: asp_pkg.sv */
// constants and types shared by the serial port and its baud timer
package asp_pkg;

    // ****************************************
    // register offsets on the plain port
    // ****************************************
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_DATA = 3'h1;
    localparam logic [2:0] OFS_TCFG = 3'h2;
    localparam logic [2:0] OFS_RELOAD = 3'h3;
    localparam logic [2:0] OFS_LOW = 3'h4;
    localparam logic [2:0] OFS_ISTAT = 3'h5;
    localparam logic [2:0] OFS_IMASK = 3'h6;

    // ****************************************
    // serial_control_reg fields
    // ****************************************
    localparam int CTL_MODE = 7;
    localparam int CTL_ONE = 6;
    localparam int CTL_MCE = 5;
    localparam int CTL_REN = 4;
    localparam int CTL_TB8 = 3;
    localparam int CTL_RB8 = 2;
    localparam int CTL_TI = 1;
    localparam int CTL_RI = 0;
    localparam logic [7:0] CTL_RESET = 8'h40;

    // ****************************************
    // timer config, interrupt bits
    // ****************************************
    localparam int TCFG_RUN = 0;
    localparam int TCFG_SEL_LSB = 1;
    localparam logic [7:0] TCFG_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam int INT_TX = 0;
    localparam int INT_RX = 1;
    localparam logic [1:0] INT_RESET = 2'h0;

    // ****************************************
    // timer clock sources and prescalers
    // ****************************************
    localparam logic [2:0] CSEL_SYS = 3'h0;
    localparam logic [2:0] CSEL_DIV4 = 3'h1;
    localparam logic [2:0] CSEL_DIV12 = 3'h2;
    localparam logic [2:0] CSEL_DIV48 = 3'h3;
    localparam logic [2:0] CSEL_OSC8 = 3'h4;
    localparam logic [2:0] CSEL_PIN = 3'h5;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [5:0] DIV48_LAST = 6'h2f;
    localparam logic [2:0] OSC8_LAST = 3'h7;
    localparam logic [7:0] TMR_TOP = 8'hff;

    // ****************************************
    // frame lengths in bit periods
    // ****************************************
    localparam logic [3:0] FRAME_8 = 4'ha;
    localparam logic [3:0] FRAME_9 = 4'hb;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_WAIT = 3'b010,
        TX_SEND = 3'b100
    } asp_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_BITS = 2'b10
    } asp_rx_st_t;

endpackage

/* File: asp_baud_if.sv */
// link between the serial port core and its baud timer
`timescale 1ns/1ps
interface asp_baud_if;
    logic run;
    logic [2:0] clk_sel;
    logic [7:0] reload;
    logic low_wr;
    logic [7:0] low_wdata;
    logic resync;
    logic [7:0] low_count;
    logic tx_tick;
    logic rx_tick;

    modport ctl (
        output run, clk_sel, reload, low_wr, low_wdata, resync,
        input low_count, tx_tick, rx_tick
    );
    modport tmr (
        input run, clk_sel, reload, low_wr, low_wdata, resync,
        output low_count, tx_tick, rx_tick
    );
endinterface

/* File: asp_baud_timer.sv */
// 8-bit auto-reload baud timer with hidden receive copy
`timescale 1ns/1ps
module asp_baud_timer
    import asp_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ext_osc_i,
    input wire logic ext_tmr_i,
    asp_baud_if.tmr bus
);

    typedef struct packed {
        logic [5:0] c48;
        logic [3:0] c12;
        logic osc_q;
        logic [2:0] osc_cnt;
        logic pin_q;
        logic [7:0] low;
        logic [7:0] rx_cnt;
        logic tx_half;
        logic rx_half;
        logic tx_tick;
        logic rx_tick;
    } asp_tmr_t;

    asp_tmr_t s;
    asp_tmr_t next_s;

    assign bus.low_count = s.low;
    assign bus.tx_tick = s.tx_tick;
    assign bus.rx_tick = s.rx_tick;

    always_comb begin
        logic tick;
        logic osc_edge;
        tick = 1'b0;
        osc_edge = ext_osc_i & ~s.osc_q;
        next_s = s;
        next_s.tx_tick = 1'b0;
        next_s.rx_tick = 1'b0;
        next_s.osc_q = ext_osc_i;
        next_s.pin_q = ext_tmr_i;
        next_s.c48 = (s.c48 == DIV48_LAST) ? 6'h00 : 6'(s.c48 + 6'h01);
        next_s.c12 = (s.c12 == DIV12_LAST) ? 4'h0 : 4'(s.c12 + 4'h1);
        if (osc_edge) begin
            next_s.osc_cnt = 3'(s.osc_cnt + 3'h1);
        end
        case (bus.clk_sel)
            CSEL_SYS: tick = 1'b1;
            CSEL_DIV4: tick = (s.c48[1:0] == DIV4_LAST);
            CSEL_DIV12: tick = (s.c12 == DIV12_LAST);
            CSEL_DIV48: tick = (s.c48 == DIV48_LAST);
            CSEL_OSC8: tick = osc_edge && (s.osc_cnt == OSC8_LAST);
            CSEL_PIN: tick = ext_tmr_i & ~s.pin_q;
            default: tick = 1'b0;
        endcase
        // low byte counts up, reloads from high byte
        // receive copy runs with the timer, same reload
        if (bus.run && tick) begin
            if (s.low == TMR_TOP) begin
                next_s.low = bus.reload;
                next_s.tx_half = ~s.tx_half;
                next_s.tx_tick = s.tx_half;
            end else begin
                next_s.low = 8'(s.low + 8'h01);
            end
            if (s.rx_cnt == TMR_TOP) begin
                next_s.rx_cnt = bus.reload;
                next_s.rx_half = ~s.rx_half;
                next_s.rx_tick = s.rx_half;
            end else begin
                next_s.rx_cnt = 8'(s.rx_cnt + 8'h01);
            end
        end
        if (bus.low_wr) begin
            next_s.low = bus.low_wdata;
        end
        // start edge forces receive reload
        // half phase set so the first tick lands mid start bit
        if (bus.resync) begin
            next_s.rx_cnt = bus.reload;
            next_s.rx_half = 1'b1;
            next_s.rx_tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

/* File: asp_serial_top.sv */
// full duplex asynchronous serial port with baud timer and register port
//
// Behaviour
// - full duplex async port, 8-bit and 9-bit variable-rate frame modes only
// - completed byte held in buffer while the next one shifts in
// - data buffer write loads transmit register, never the receive buffer
// - data buffer read returns receive buffer; transmit register unreadable
// - interrupt requested when transmit-done or receive-done becomes set
// - done flags stay set until software writes them clear
// - bit rate from 8-bit timer auto-reloading from its high byte
// - transmit clock from low count; receive clock from hidden copy
// - both overflow streams halved to give the bit rates
// - receive copy counts when timer runs, same reload byte
// - start edge on receive pin forces receive copy reload
// - timer clock from six selectable sources
// - bit rate is half of clock over 256 minus reload
// - 8-bit frame: start, 8 data lsb first, stop; stop into rx ninth bit
// - 9-bit frame: start, 8 data, tx ninth bit, stop; stop ignored
// - load only when rx done clear and, with checking on, ninth bit one
// - transmit starts on buffer write; done flag at stop bit start
`timescale 1ns/1ps
module asp_serial_top
    import asp_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic ext_osc_i,
    input wire logic ext_tmr_i,
    output logic irq_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic mode;
        logic mce;
        logic ren;
        logic tb8;
        logic rb8;
        logic ti;
        logic ri;
        logic [7:0] rx_buf;
        logic [7:0] tx_data;
        logic tx_pend;
        asp_tx_st_t tx_st;
        logic [10:0] tx_frame;
        logic [3:0] tx_cnt;
        logic txd;
        asp_rx_st_t rx_st;
        logic [8:0] rx_shift;
        logic [3:0] rx_cnt;
        logic rxd_q;
        logic [1:0] int_stat;
        logic [1:0] int_mask;
        logic irq;
        logic tmr_run;
        logic [2:0] clk_sel;
        logic [7:0] reload;
        logic [7:0] rdata;
    } asp_state_t;

    asp_state_t s;
    asp_state_t next_s;

    logic wr_ctrl;
    logic wr_data;
    logic wr_tcfg;
    logic wr_reload;
    logic wr_istat;
    logic wr_imask;
    logic start_edge;

    asp_baud_if baud ();

    // ****************************************
    // baud timer
    // ****************************************
    asp_baud_timer u_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ext_osc_i(ext_osc_i),
        .ext_tmr_i(ext_tmr_i),
        .bus(baud.tmr)
    );

    assign baud.run = s.tmr_run;
    assign baud.clk_sel = s.clk_sel;
    // reload chosen by software, used as written
    assign baud.reload = s.reload;
    assign baud.low_wr = wr_i && (addr_i == OFS_LOW);
    assign baud.low_wdata = wdata_i;
    // falling edge while idle and enabled
    assign baud.resync = start_edge;

    // ****************************************
    // register decode
    // ****************************************
    assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
    assign wr_data = wr_i && (addr_i == OFS_DATA);
    assign wr_tcfg = wr_i && (addr_i == OFS_TCFG);
    assign wr_reload = wr_i && (addr_i == OFS_RELOAD);
    assign wr_istat = wr_i && (addr_i == OFS_ISTAT);
    assign wr_imask = wr_i && (addr_i == OFS_IMASK);
    // idle high, a high-to-low step marks a start
    assign start_edge = (s.rx_st == RX_IDLE) && s.ren && s.rxd_q && !rxd_i;

    assign rdata_o = s.rdata;
    assign txd_o = s.txd;
    assign irq_o = s.irq;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic ti_set;
        logic ri_set;
        logic [10:0] frame;
        logic [3:0] rx_last;
        logic [7:0] rx_byte;
        logic rx_ninth;
        logic [1:0] clr;
        ti_set = 1'b0;
        ri_set = 1'b0;
        frame = '0;
        rx_last = s.mode ? 4'(FRAME_9 - 4'h1) : 4'(FRAME_8 - 4'h1);
        rx_byte = s.mode ? s.rx_shift[7:0] : s.rx_shift[8:1];
        rx_ninth = s.mode ? s.rx_shift[8] : rxd_i;
        clr = 2'h0;
        next_s = s;
        next_s.rxd_q = rxd_i;
        next_s.rdata = 8'h00;

        // ------------ transmitter ------------
        // frame length follows the mode bit
        unique case (s.tx_st)
            TX_IDLE: begin
                if (s.tx_pend) begin
                    next_s.tx_st = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (baud.tx_tick) begin
                    // start, 8 data lsb first, stop
                    // ninth bit from tx_ninth_bit before stop
                    if (s.mode) begin
                        frame = {1'b1, s.tb8, s.tx_data, 1'b0};
                        next_s.tx_cnt = 4'(FRAME_9 - 4'h1);
                    end else begin
                        frame = {2'b11, s.tx_data, 1'b0};
                        next_s.tx_cnt = 4'(FRAME_8 - 4'h1);
                    end
                    // start bit is low for one bit period
                    next_s.txd = frame[0];
                    next_s.tx_frame = {1'b1, frame[10:1]};
                    next_s.tx_pend = 1'b0;
                    next_s.tx_st = TX_SEND;
                end
            end
            TX_SEND: begin
                if (baud.tx_tick) begin
                    if (s.tx_cnt == 4'h0) begin
                        next_s.txd = 1'b1;
                        next_s.tx_st = TX_IDLE;
                    end else begin
                        next_s.txd = s.tx_frame[0];
                        next_s.tx_frame = {1'b1, s.tx_frame[10:1]};
                        next_s.tx_cnt = 4'(s.tx_cnt - 4'h1);
                        // done flag as the stop bit begins
                        if (s.tx_cnt == 4'h1) begin
                            ti_set = 1'b1;
                        end
                    end
                end
            end
        endcase

        // write always lands in the transmit register
        // a write starts a frame, queued if one is running
        if (wr_data) begin
            next_s.tx_data = wdata_i;
            next_s.tx_pend = 1'b1;
        end

        // ------------ receiver ------------
        // sampling paced by the hidden receive copy
        unique case (s.rx_st)
            RX_IDLE: begin
                if (start_edge) begin
                    next_s.rx_cnt = 4'h0;
                    next_s.rx_st = RX_BITS;
                end
            end
            RX_BITS: begin
                if (!s.ren) begin
                    next_s.rx_st = RX_IDLE;
                end else if (baud.rx_tick) begin
                    if (s.rx_cnt == 4'h0) begin
                        // false start: line back high at mid bit
                        if (rxd_i) begin
                            next_s.rx_st = RX_IDLE;
                        end else begin
                            next_s.rx_cnt = 4'h1;
                        end
                    end else if (s.rx_cnt == rx_last) begin
                        // load only into a free buffer, address check
                        if (!s.ri && (!s.mce || rx_ninth)) begin
                            // shift register stays separate from buffer
                            next_s.rx_buf = rx_byte;
                            // stop bit, ninth bit, into rx ninth
                            next_s.rb8 = rx_ninth;
                            ri_set = 1'b1;
                        end
                        next_s.rx_st = RX_IDLE;
                    end else begin
                        next_s.rx_shift = {rxd_i, s.rx_shift[8:1]};
                        next_s.rx_cnt = 4'(s.rx_cnt + 4'h1);
                    end
                end
            end
        endcase

        // ------------ control and flags ------------
        if (wr_ctrl) begin
            next_s.mode = wdata_i[CTL_MODE];
            next_s.mce = wdata_i[CTL_MCE];
            next_s.ren = wdata_i[CTL_REN];
            next_s.tb8 = wdata_i[CTL_TB8];
            next_s.rb8 = wdata_i[CTL_RB8];
            next_s.ti = wdata_i[CTL_TI];
            next_s.ri = wdata_i[CTL_RI];
        end
        // only software clears; a set in the same cycle wins
        if (ti_set) begin
            next_s.ti = 1'b1;
        end
        if (ri_set) begin
            next_s.ri = 1'b1;
            next_s.rb8 = rx_ninth;
        end

        if (wr_tcfg) begin
            next_s.tmr_run = wdata_i[TCFG_RUN];
            next_s.clk_sel = wdata_i[TCFG_SEL_LSB +: 3];
        end
        // overflow period is 256 minus this byte
        if (wr_reload) begin
            next_s.reload = wdata_i;
        end

        // ------------ interrupt ------------
        if (wr_istat) begin
            clr = wdata_i[1:0];
        end
        if (wr_imask) begin
            next_s.int_mask = wdata_i[1:0];
        end
        // event sticky bits, set wins over write-one clear
        next_s.int_stat = (s.int_stat & ~clr) | {ri_set, ti_set};
        next_s.irq = |(next_s.int_stat & next_s.int_mask);

        // ------------ read port ------------
        if (rd_i) begin
            case (addr_i)
                OFS_CTRL: begin
                    next_s.rdata = {s.mode, 1'b1, s.mce, s.ren,
                                    s.tb8, s.rb8, s.ti, s.ri};
                end
                // reads see only the receive buffer
                OFS_DATA: next_s.rdata = s.rx_buf;
                OFS_TCFG: next_s.rdata = {4'h0, s.clk_sel, s.tmr_run};
                OFS_RELOAD: next_s.rdata = s.reload;
                OFS_LOW: next_s.rdata = baud.low_count;
                OFS_ISTAT: next_s.rdata = {6'h00, s.int_stat};
                OFS_IMASK: next_s.rdata = {6'h00, s.int_mask};
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s.mode <= CTL_RESET[CTL_MODE];
            s.mce <= CTL_RESET[CTL_MCE];
            s.ren <= CTL_RESET[CTL_REN];
            s.tb8 <= CTL_RESET[CTL_TB8];
            s.rb8 <= CTL_RESET[CTL_RB8];
            s.ti <= CTL_RESET[CTL_TI];
            s.ri <= CTL_RESET[CTL_RI];
            s.rx_buf <= 8'h00;
            s.tx_data <= 8'h00;
            s.tx_pend <= 1'b0;
            s.tx_st <= TX_IDLE;
            s.tx_frame <= 11'h7ff;
            s.tx_cnt <= 4'h0;
            s.txd <= 1'b1;
            s.rx_st <= RX_IDLE;
            s.rx_shift <= 9'h000;
            s.rx_cnt <= 4'h0;
            s.rxd_q <= 1'b1;
            s.int_stat <= INT_RESET;
            s.int_mask <= INT_RESET;
            s.irq <= 1'b0;
            s.tmr_run <= TCFG_RESET[TCFG_RUN];
            s.clk_sel <= TCFG_RESET[TCFG_SEL_LSB +: 3];
            s.reload <= RELOAD_RESET;
            s.rdata <= 8'h00;
        end else begin
            s <= next_s;
        end
    end

endmodule

/* File: asp_serial_top_asserts.sv */
// property checks on the serial port top pins
`timescale 1ns/1ps
module asp_serial_top_asserts
    import asp_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic rxd_i,
    input wire logic txd_o,
    input wire logic ext_osc_i,
    input wire logic ext_tmr_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ********
    // register port
    // ********
    a_rdata_idle: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside answer cycle");
    a_read_unmapped: assert property (
        rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_fixed_one: assert property (
        rd_i && addr_i == OFS_CTRL |=> rdata_o[CTL_ONE])
        else $error("control bit 6 not one");
    a_tcfg_upper_zero: assert property (
        rd_i && addr_i == OFS_TCFG |=> rdata_o[7:4] == 4'h0)
        else $error("timer config upper bits set");
    a_write_no_answer: assert property (
        wr_i |=> rdata_o == 8'h00)
        else $error("write produced read data");

    // ********
    // interrupt and line
    // ********
    a_irq_mask_off: assert property (
        wr_i && addr_i == OFS_IMASK && wdata_i[1:0] == 2'h0 |-> ##2 !irq_o)
        else $error("irq high with mask clear");
    a_bit_min_len: assert property (
        $changed(txd_o) |=> $stable(txd_o))
        else $error("serial bit shorter than two clocks");
    a_reset_outputs: assert property (
        $rose(nrst_i) |-> txd_o && !irq_o && rdata_o == 8'h00)
        else $error("outputs wrong after reset");
endmodule

bind asp_serial_top asp_serial_top_asserts u_asp_serial_top_asserts (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .rxd_i(rxd_i),
    .txd_o(txd_o),
    .ext_osc_i(ext_osc_i),
    .ext_tmr_i(ext_tmr_i),
    .irq_o(irq_o)
);

/* File: asp_line_model.sv */
// remote serial station: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps
module asp_line_model #(
    parameter int BIT_CLKS = 4
) (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic nine_i,
    output logic rxd_o,
    output logic [7:0] got_data_o,
    output logic got_ninth_o,
    output logic got_stop_o,
    output logic [7:0] got_count_o
);
    initial begin
        got_data_o = 8'h00;
        got_ninth_o = 1'b0;
        got_stop_o = 1'b0;
        got_count_o = 8'h00;
        forever begin
            @(negedge txd_i);
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge clk_i);
                got_data_o[i] = txd_i;
            end
            if (nine_i) begin
                repeat (BIT_CLKS) @(posedge clk_i);
                got_ninth_o = txd_i;
            end
            repeat (BIT_CLKS) @(posedge clk_i);
            got_stop_o = txd_i;
            got_count_o = got_count_o + 8'h01;
        end
    end

    initial rxd_o = 1'b1;

    // start low, data lsb first, ninth only when nine_i, stop
    task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
        logic [10:0] f;
        int n;
        f = nine_i ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
        n = nine_i ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            rxd_o <= f[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

/* File: tb.sv */
// self-checking bench for the serial port with baud timer
`timescale 1ns/1ps
module tb
    import asp_pkg::*;
;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic ext_osc = 1'b0;
    logic ext_tmr = 1'b0;
    logic nine = 1'b0;
    logic rxd;
    logic txd;
    logic irq;
    logic [7:0] rdata;
    logic [7:0] got_data;
    logic [7:0] got_count;
    logic got_ninth;
    logic got_stop;
    logic [7:0] n;
    int bad_count = 0;
    int compares = 0;

    always #10 clk_i = ~clk_i;

    asp_serial_top u_asp_serial_top (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .addr_i(addr),
        .wdata_i(wdata),
        .wr_i(wr_s),
        .rd_i(rd_s),
        .rdata_o(rdata),
        .rxd_i(rxd),
        .txd_o(txd),
        .ext_osc_i(ext_osc),
        .ext_tmr_i(ext_tmr),
        .irq_o(irq)
    );

    // reload 0xfe on the system clock gives four clocks a bit
    asp_line_model #(.BIT_CLKS(4)) u_asp_line_model (
        .clk_i(clk_i),
        .txd_i(txd),
        .nine_i(nine),
        .rxd_o(rxd),
        .got_data_o(got_data),
        .got_ninth_o(got_ninth),
        .got_stop_o(got_stop),
        .got_count_o(got_count)
    );

    // ********
    // shared tasks
    // ********
    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_i);
        wr_s <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1 d = rdata;
        @(posedge clk_i);
        chk(nm, e, d);
    endtask

    task automatic pulses(input logic pin, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            if (pin) ext_tmr <= 1'b1;
            else ext_osc <= 1'b1;
            repeat (2) @(posedge clk_i);
            ext_tmr <= 1'b0;
            ext_osc <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask

    task automatic wait_tx(input logic [7:0] old);
        int k;
        k = 0;
        while (got_count === old && k < 600) begin
            @(posedge clk_i);
            k++;
        end
        // limit running out is a failure, not a silent return
        if (k >= 600) chk("tx timeout", 8'h01, 8'h00);
    endtask

    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 600) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 600) chk("irq timeout", 8'h01, 8'h00);
    endtask

    // 48 counted edges hold a whole prescaler cycle, so phase does not matter
    task automatic div_chk(input logic [2:0] sel, input logic [7:0] e, input string nm);
        wr(OFS_TCFG, {4'h0, sel, 1'b1});
        wr(OFS_LOW, 8'h00);
        repeat (47) @(posedge clk_i);
        rchk(OFS_LOW, e, nm);
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_reset();
        rchk(OFS_CTRL, CTL_RESET, "ctrl");
        rchk(OFS_TCFG, TCFG_RESET, "tcfg");
        rchk(OFS_RELOAD, RELOAD_RESET, "reload");
        rchk(OFS_ISTAT, 8'h00, "istat");
        rchk(OFS_DATA, 8'h00, "rxbuf");
        wr(3'h7, 8'hff);
        rchk(3'h7, 8'h00, "unmapped");
    endtask

    task automatic t_clk_src();
        wr(OFS_RELOAD, 8'hfc);
        wr(OFS_LOW, 8'hfe);
        wr(OFS_TCFG, {4'h0, CSEL_PIN, 1'b1});
        pulses(1'b1, 3);
        rchk(OFS_LOW, 8'hfd, "pin reload");
        wr(OFS_LOW, 8'h00);
        wr(OFS_TCFG, {4'h0, CSEL_OSC8, 1'b1});
        pulses(1'b0, 16);
        rchk(OFS_LOW, 8'h02, "osc div8");
        div_chk(CSEL_SYS, 8'h30, "sys clk");
        div_chk(CSEL_DIV4, 8'h0c, "div4");
        div_chk(CSEL_DIV12, 8'h04, "div12");
        div_chk(CSEL_DIV48, 8'h01, "div48");
    endtask

    task automatic t_tx();
        wr(OFS_RELOAD, 8'hfe);
        wr(OFS_TCFG, {4'h0, CSEL_SYS, 1'b1});
        wr(OFS_IMASK, 8'h02);
        wr(OFS_CTRL, 8'h10);
        n = got_count;
        wr(OFS_DATA, 8'ha5);
        wait_tx(n);
        chk("tx data", 8'ha5, got_data);
        chk("tx stop", 8'h01, {7'h0, got_stop});
        chk("irq masked", 8'h00, {7'h0, irq});
        rchk(OFS_ISTAT, 8'h01, "istat tx");
        rchk(OFS_CTRL, 8'h52, "tx done");
        rchk(OFS_DATA, 8'h00, "rx untouched");
        wr(OFS_IMASK, 8'h03);
        chk("irq unmasked", 8'h01, {7'h0, irq});
        wr(OFS_ISTAT, 8'h01);
        wr(OFS_CTRL, 8'h10);
        chk("irq cleared", 8'h00, {7'h0, irq});
    endtask

    task automatic t_rx();
        u_asp_line_model.send(8'h3c, 1'b0, 1'b1);
        wait_irq();
        chk("irq rx", 8'h01, {7'h0, irq});
        rchk(OFS_DATA, 8'h3c, "rx data");
        rchk(OFS_CTRL, 8'h55, "rx flags");
        u_asp_line_model.send(8'hc3, 1'b0, 1'b1);
        rchk(OFS_DATA, 8'h3c, "held");
        wr(OFS_ISTAT, 8'h02);
        wr(OFS_CTRL, 8'h30);
        u_asp_line_model.send(8'h96, 1'b0, 1'b0);
        rchk(OFS_ISTAT, 8'h00, "bad stop");
        u_asp_line_model.send(8'h69, 1'b0, 1'b1);
        rchk(OFS_DATA, 8'h69, "good stop");
    endtask

    task automatic t_nine();
        wr(OFS_ISTAT, 8'h03);
        nine <= 1'b1;
        wr(OFS_CTRL, 8'hb8);
        n = got_count;
        wr(OFS_DATA, 8'h5a);
        wait_tx(n);
        chk("tx9 data", 8'h5a, got_data);
        chk("tx9 ninth", 8'h01, {7'h0, got_ninth});
        chk("tx9 stop", 8'h01, {7'h0, got_stop});
        wr(OFS_ISTAT, 8'h01);
        u_asp_line_model.send(8'h11, 1'b0, 1'b1);
        rchk(OFS_ISTAT, 8'h00, "ninth zero");
        u_asp_line_model.send(8'h22, 1'b1, 1'b0);
        rchk(OFS_DATA, 8'h22, "ninth one");
        rchk(OFS_CTRL, 8'hff, "rx9 flags");
        wr(OFS_IMASK, 8'h00);
        chk("irq mask off", 8'h00, {7'h0, irq});
    endtask

    // whole run is under a thousand clocks
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_clk_src();
        t_tx();
        t_rx();
        t_nine();
        stop_test();
    end
endmodule
